// file: rtl/fpq_pkg.sv
// ==========================================
// Constants, types and timing for the flash protection and query controller
// Assumes a 250 MHz system clock and a word-mode parallel flash
package fpq_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CNT_W = 8;

  // ==========================================
  // Pin timing, least times in ns
  localparam int T_SU_NS = 10;
  localparam int T_WP_NS = 40;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACC_NS = 100;
  localparam int T_RP_NS = 500;

  function automatic int nsToCyc(input int ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction : nsToCyc

  localparam logic [CNT_W-1:0] CYC_SU = CNT_W'(nsToCyc(T_SU_NS));
  localparam logic [CNT_W-1:0] CYC_WP = CNT_W'(nsToCyc(T_WP_NS));
  localparam logic [CNT_W-1:0] CYC_HOLD = CNT_W'(nsToCyc(T_HOLD_NS));
  localparam logic [CNT_W-1:0] CYC_ACC = CNT_W'(nsToCyc(T_ACC_NS));
  localparam logic [CNT_W-1:0] CYC_RP = CNT_W'(nsToCyc(T_RP_NS));
  localparam logic [CNT_W-1:0] CYC_SYNC = 8'h02;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // ==========================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_HV = 8;
  localparam int CTRL_LOCK = 9;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_QRY = 3;
  localparam int ST_REGION = 4;
  localparam int ST_QUERY = 5;
  localparam int ST_HV = 6;

  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_READ = 3'h1,
    OP_QRY_ENTER = 3'h2,
    OP_RESET = 3'h3,
    OP_REG_ENTER = 3'h4,
    OP_REG_EXIT = 3'h5,
    OP_QRY_CHECK = 3'h6,
    OP_CHIP_RST = 3'h7
  } fpq_op_t;

  // ==========================================
  // Flash command words
  localparam logic [ADDR_W-1:0] ADR_QUERY = 21'h000055;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 21'h000555;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 21'h0002AA;
  localparam logic [ADDR_W-1:0] ADR_QRY0 = 21'h000010;
  localparam logic [ADDR_W-1:0] REGION_WORDS = 21'h000080;
  localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_REG_ENTER = 16'h0088;
  localparam logic [DATA_W-1:0] CMD_REG_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_REG_EXIT2 = 16'h0000;
  localparam logic [DATA_W-1:0] QRY_Q = 16'h0051;
  localparam logic [DATA_W-1:0] QRY_R = 16'h0052;
  localparam logic [DATA_W-1:0] QRY_Y = 16'h0059;
endpackage : fpq_pkg

// file: rtl/fpq_bus_cycle.sv
// ==========================================
// One asynchronous flash bus cycle, read or write, on the control pins
// Assumes start only while idle; data pin input is asynchronous
module fpq_bus_cycle (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [fpq_pkg::ADDR_W-1:0] cycAddr,
  input wire logic [fpq_pkg::DATA_W-1:0] cycData,
  output logic done,
  output logic [fpq_pkg::DATA_W-1:0] rdata,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [fpq_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [fpq_pkg::DATA_W-1:0] flashDqIn,
  output logic [fpq_pkg::DATA_W-1:0] flashDqOut,
  output logic flashDqOe
);
  typedef enum logic [4:0] {
    C_IDLE = 5'b00001,
    C_SETUP = 5'b00010,
    C_STROBE = 5'b00100,
    C_HOLD = 5'b01000,
    C_READ = 5'b10000
  } fpq_cyc_t;

  typedef struct packed {
    fpq_cyc_t st;
    logic [fpq_pkg::CNT_W-1:0] cnt;
    logic ceN;
    logic oeN;
    logic weN;
    logic dqOe;
    logic [fpq_pkg::ADDR_W-1:0] adr;
    logic [fpq_pkg::DATA_W-1:0] dqOut;
    logic [fpq_pkg::DATA_W-1:0] sync1;
    logic [fpq_pkg::DATA_W-1:0] sync2;
    logic [fpq_pkg::DATA_W-1:0] rdata;
    logic done;
  } fpq_cyc_s_t;

  fpq_cyc_s_t s_ff;
  fpq_cyc_s_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.sync1 = flashDqIn;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.cnt = s_ff.cnt - fpq_pkg::CNT_ONE;
    case (s_ff.st)
      C_IDLE: begin
        nxt_s.cnt = s_ff.cnt;
        if (start) begin
          nxt_s.adr = cycAddr;
          nxt_s.dqOut = cycData;
          nxt_s.ceN = 1'b0;
          if (isWrite) begin
            nxt_s.dqOe = 1'b1;
            nxt_s.cnt = fpq_pkg::CYC_SU;
            nxt_s.st = C_SETUP;
          end else begin
            nxt_s.oeN = 1'b0;
            nxt_s.cnt = fpq_pkg::CYC_ACC + fpq_pkg::CYC_SYNC;
            nxt_s.st = C_READ;
          end
        end
      end
      C_SETUP: begin
        if (s_ff.cnt == fpq_pkg::CNT_ONE) begin
          // Write starts only with select low and output gate high
          nxt_s.weN = ~(~s_ff.ceN & s_ff.oeN);
          nxt_s.cnt = fpq_pkg::CYC_WP;
          nxt_s.st = C_STROBE;
        end
      end
      C_STROBE: begin
        if (s_ff.cnt == fpq_pkg::CNT_ONE) begin
          nxt_s.weN = 1'b1;
          nxt_s.cnt = fpq_pkg::CYC_HOLD;
          nxt_s.st = C_HOLD;
        end
      end
      C_HOLD: begin
        if (s_ff.cnt == fpq_pkg::CNT_ONE) begin
          nxt_s.ceN = 1'b1;
          nxt_s.dqOe = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st = C_IDLE;
        end
      end
      C_READ: begin
        if (s_ff.cnt == fpq_pkg::CNT_ONE) begin
          nxt_s.rdata = s_ff.sync2;
          nxt_s.ceN = 1'b1;
          nxt_s.oeN = 1'b1;
          nxt_s.done = 1'b1;
          nxt_s.st = C_IDLE;
        end
      end
      default: begin
        nxt_s.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '{st: C_IDLE, ceN: 1'b1, oeN: 1'b1, weN: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;
  assign rdata = s_ff.rdata;
  assign flashCeN = s_ff.ceN;
  assign flashOeN = s_ff.oeN;
  assign flashWeN = s_ff.weN;
  assign flashAddr = s_ff.adr;
  assign flashDqOut = s_ff.dqOut;
  assign flashDqOe = s_ff.dqOe;

  // ==========================================
  // Checks
  strobe_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !flashWeN |-> (!flashCeN && flashOeN && flashDqOe))
    else $error("write strobe low without select or with output gate low");

  sequence strobeFall_s;
    $fell(flashWeN);
  endsequence

  strobe_width_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    strobeFall_s |-> (!flashWeN)[*8] ##[1:4] flashWeN ##1 flashDqOe)
    else $error("write strobe width or data hold wrong");

  gate_excl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !flashOeN |-> (flashWeN && !flashDqOe))
    else $error("output gate low while driving or strobing");
endmodule : fpq_bus_cycle

// file: rtl/fpq_ctrl.sv
// ==========================================
// Host controller for a parallel NOR flash: commands, query, secured region
// Assumes APB3 register access and a flash in word mode on the pins below
//
// Local design decisions: the register addresses and the APB interface to the registers.
module fpq_ctrl (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [fpq_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [fpq_pkg::DATA_W-1:0] flashDqIn,
  output logic [fpq_pkg::DATA_W-1:0] flashDqOut,
  output logic flashDqOe,
  output logic flashRstN,
  output logic flashHvEn,
  output logic flashEdgeLockN
);
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_ISSUE = 3'b010,
    M_WAIT = 3'b100
  } fpq_main_t;

  typedef struct packed {
    fpq_main_t st;
    fpq_pkg::fpq_op_t op;
    logic [1:0] idx;
    logic [fpq_pkg::CNT_W-1:0] cnt;
    logic [fpq_pkg::ADDR_W-1:0] addr;
    logic [fpq_pkg::DATA_W-1:0] wdata;
    logic [fpq_pkg::DATA_W-1:0] rdata;
    logic hvEn;
    logic lockN;
    logic rstN;
    logic done;
    logic err;
    logic qryOk;
    logic regionOn;
    logic queryOn;
    logic cycStart;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fpq_main_s_t;

  // Step of a command sequence: last, write, address, data
  typedef struct packed {
    logic last;
    logic wr;
    logic [fpq_pkg::ADDR_W-1:0] adr;
    logic [fpq_pkg::DATA_W-1:0] dat;
  } fpq_step_t;

  fpq_main_s_t s_ff;
  fpq_main_s_t nxt_s;
  fpq_step_t step;
  logic cycDone;
  logic [fpq_pkg::DATA_W-1:0] cycRdata;
  logic apbAccess;
  logic apbWrite;
  logic startReq;
  fpq_pkg::fpq_op_t reqOp;

  function automatic fpq_step_t seqStep(input fpq_pkg::fpq_op_t op, input logic [1:0] idx,
                                        input logic [fpq_pkg::ADDR_W-1:0] adr,
                                        input logic [fpq_pkg::DATA_W-1:0] dat);
    fpq_step_t r;
    r = '{last: 1'b1, wr: 1'b1, adr: adr, dat: dat};
    case (op)
      fpq_pkg::OP_READ: r.wr = 1'b0;
      fpq_pkg::OP_QRY_ENTER: r = '{1'b1, 1'b1, fpq_pkg::ADR_QUERY, fpq_pkg::CMD_QUERY};
      fpq_pkg::OP_RESET: r.dat = fpq_pkg::CMD_RESET;
      fpq_pkg::OP_REG_ENTER, fpq_pkg::OP_REG_EXIT: begin
        case (idx)
          2'h0: r = '{1'b0, 1'b1, fpq_pkg::ADR_UNLOCK1, fpq_pkg::CMD_UNLOCK1};
          2'h1: r = '{1'b0, 1'b1, fpq_pkg::ADR_UNLOCK2, fpq_pkg::CMD_UNLOCK2};
          2'h2: begin
            r = '{1'b1, 1'b1, fpq_pkg::ADR_UNLOCK1, fpq_pkg::CMD_REG_ENTER};
            if (op == fpq_pkg::OP_REG_EXIT) begin
              r = '{1'b0, 1'b1, fpq_pkg::ADR_UNLOCK1, fpq_pkg::CMD_REG_EXIT1};
            end
          end
          default: r = '{1'b1, 1'b1, adr, fpq_pkg::CMD_REG_EXIT2};
        endcase
      end
      fpq_pkg::OP_QRY_CHECK: begin
        r = '{idx == 2'h2, 1'b0, fpq_pkg::ADR_QRY0 + fpq_pkg::ADDR_W'(idx), 16'h0000};
      end
      default: r = '{1'b1, 1'b1, adr, dat};
    endcase
    return r;
  endfunction : seqStep

  // Letter expected at each word of the query string
  function automatic logic [fpq_pkg::DATA_W-1:0] qryLetter(input logic [1:0] idx);
    case (idx)
      2'h0: return fpq_pkg::QRY_Q;
      2'h1: return fpq_pkg::QRY_R;
      default: return fpq_pkg::QRY_Y;
    endcase
  endfunction : qryLetter

  // Orders the host may not give in the current mode
  function automatic logic refused(input fpq_pkg::fpq_op_t op, input logic regionOn,
                                   input logic queryOn, input logic [fpq_pkg::ADDR_W-1:0] adr);
    logic r;
    r = 1'b0;
    if (regionOn && (op == fpq_pkg::OP_WRITE || op == fpq_pkg::OP_READ)) begin
      r = (adr >= fpq_pkg::REGION_WORDS);
    end
    if (regionOn && (op == fpq_pkg::OP_QRY_ENTER || op == fpq_pkg::OP_QRY_CHECK)) begin
      r = 1'b1;
    end
    if (queryOn && (op == fpq_pkg::OP_WRITE || op == fpq_pkg::OP_REG_ENTER)) begin
      r = 1'b1;
    end
    return r;
  endfunction : refused

  assign apbAccess = psel & penable & s_ff.pready;
  assign apbWrite = apbAccess & pwrite;
  assign startReq = apbWrite & (paddr == fpq_pkg::OFS_CTRL) & pwdata[fpq_pkg::CTRL_START];
  assign reqOp = fpq_pkg::fpq_op_t'(pwdata[fpq_pkg::CTRL_OP_LSB +: 3]);
  assign step = seqStep(s_ff.op, s_ff.idx, s_ff.addr, s_ff.wdata);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.cycStart = 1'b0;
    // ==========================================
    // APB slave, zero wait: ready follows the setup cycle
    nxt_s.pready = psel & ~penable;
    nxt_s.pslverr = 1'b0;
    if (psel && !penable) begin
      nxt_s.prdata = 32'h00000000;
      case (paddr)
        fpq_pkg::OFS_CTRL: begin
          nxt_s.prdata[fpq_pkg::CTRL_OP_LSB +: 3] = s_ff.op;
          nxt_s.prdata[fpq_pkg::CTRL_HV] = s_ff.hvEn;
          nxt_s.prdata[fpq_pkg::CTRL_LOCK] = ~s_ff.lockN;
        end
        fpq_pkg::OFS_ADDR: nxt_s.prdata[fpq_pkg::ADDR_W-1:0] = s_ff.addr;
        fpq_pkg::OFS_WDATA: nxt_s.prdata[fpq_pkg::DATA_W-1:0] = s_ff.wdata;
        fpq_pkg::OFS_STAT: begin
          nxt_s.prdata[fpq_pkg::ST_BUSY] = (s_ff.st != M_IDLE);
          nxt_s.prdata[fpq_pkg::ST_DONE] = s_ff.done;
          nxt_s.prdata[fpq_pkg::ST_ERR] = s_ff.err;
          nxt_s.prdata[fpq_pkg::ST_QRY] = s_ff.qryOk;
          nxt_s.prdata[fpq_pkg::ST_REGION] = s_ff.regionOn;
          nxt_s.prdata[fpq_pkg::ST_QUERY] = s_ff.queryOn;
          nxt_s.prdata[fpq_pkg::ST_HV] = s_ff.hvEn;
        end
        fpq_pkg::OFS_RDATA: nxt_s.prdata[fpq_pkg::DATA_W-1:0] = s_ff.rdata;
        default: nxt_s.pslverr = 1'b1;
      endcase
    end
    if (apbWrite) begin
      case (paddr)
        fpq_pkg::OFS_CTRL: begin
          nxt_s.hvEn = pwdata[fpq_pkg::CTRL_HV];
          nxt_s.lockN = ~pwdata[fpq_pkg::CTRL_LOCK];
        end
        fpq_pkg::OFS_ADDR: nxt_s.addr = pwdata[fpq_pkg::ADDR_W-1:0];
        fpq_pkg::OFS_WDATA: nxt_s.wdata = pwdata[fpq_pkg::DATA_W-1:0];
        fpq_pkg::OFS_STAT: begin
          if (pwdata[fpq_pkg::ST_DONE]) nxt_s.done = 1'b0;
          if (pwdata[fpq_pkg::ST_ERR]) nxt_s.err = 1'b0;
        end
        default: nxt_s.err = s_ff.err;
      endcase
    end
    // ==========================================
    // Sequencer
    case (s_ff.st)
      M_IDLE: begin
        if (startReq) begin
          if (refused(reqOp, s_ff.regionOn, s_ff.queryOn, s_ff.addr)) begin
            nxt_s.err = 1'b1;
          end else begin
            nxt_s.op = reqOp;
            nxt_s.idx = 2'h0;
            nxt_s.done = 1'b0;
            nxt_s.err = 1'b0;
            if (reqOp == fpq_pkg::OP_CHIP_RST) begin
              nxt_s.rstN = 1'b0;
              nxt_s.cnt = fpq_pkg::CYC_RP;
              nxt_s.st = M_WAIT;
            end else begin
              nxt_s.st = M_ISSUE;
            end
            if (reqOp == fpq_pkg::OP_QRY_CHECK) nxt_s.qryOk = 1'b1;
          end
        end
      end
      M_ISSUE: begin
        nxt_s.cycStart = 1'b1;
        nxt_s.st = M_WAIT;
      end
      M_WAIT: begin
        if (s_ff.op == fpq_pkg::OP_CHIP_RST) begin
          nxt_s.cnt = s_ff.cnt - fpq_pkg::CNT_ONE;
          if (s_ff.cnt == fpq_pkg::CNT_ONE) begin
            nxt_s.rstN = 1'b1;
            nxt_s.regionOn = 1'b0;
            nxt_s.queryOn = 1'b0;
            nxt_s.done = 1'b1;
            nxt_s.st = M_IDLE;
          end
        end else if (cycDone) begin
          if (!step.wr) nxt_s.rdata = cycRdata;
          if (s_ff.op == fpq_pkg::OP_QRY_CHECK && cycRdata != qryLetter(s_ff.idx)) begin
            nxt_s.qryOk = 1'b0;
          end
          if (step.last) begin
            nxt_s.done = 1'b1;
            nxt_s.st = M_IDLE;
            case (s_ff.op)
              fpq_pkg::OP_QRY_ENTER: nxt_s.queryOn = 1'b1;
              fpq_pkg::OP_RESET: nxt_s.queryOn = 1'b0;
              fpq_pkg::OP_REG_ENTER: nxt_s.regionOn = 1'b1;
              fpq_pkg::OP_REG_EXIT: nxt_s.regionOn = 1'b0;
              default: nxt_s.regionOn = s_ff.regionOn;
            endcase
          end else begin
            nxt_s.idx = s_ff.idx + 2'h1;
            nxt_s.st = M_ISSUE;
          end
        end
      end
      default: nxt_s.st = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '{st: M_IDLE, op: fpq_pkg::OP_WRITE, rstN: 1'b1, lockN: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  fpq_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(s_ff.cycStart),
    .isWrite(step.wr),
    .cycAddr(step.adr),
    .cycData(step.dat),
    .done(cycDone),
    .rdata(cycRdata),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .flashAddr(flashAddr),
    .flashDqIn(flashDqIn),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe)
  );

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign flashRstN = s_ff.rstN;
  assign flashHvEn = s_ff.hvEn;
  assign flashEdgeLockN = s_ff.lockN;

  // ==========================================
  // Checks
  region_enter_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(s_ff.regionOn) |-> $past(s_ff.op) == fpq_pkg::OP_REG_ENTER && $past(s_ff.idx) == 2'h2)
    else $error("secured region flagged without full enter sequence");

  region_bound_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (s_ff.cycStart && s_ff.regionOn && s_ff.op inside {fpq_pkg::OP_WRITE, fpq_pkg::OP_READ})
      |-> step.adr < fpq_pkg::REGION_WORDS)
    else $error("array access outside region before exit sequence");

  query_leave_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(s_ff.queryOn) |-> $past(s_ff.op) inside {fpq_pkg::OP_RESET, fpq_pkg::OP_CHIP_RST})
    else $error("query mode left without reset command");

  query_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (s_ff.cycStart && s_ff.queryOn && step.wr) |->
      s_ff.op inside {fpq_pkg::OP_RESET, fpq_pkg::OP_REG_EXIT, fpq_pkg::OP_QRY_ENTER})
    else $error("non-reset write while in query mode");

  apb_ready_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("register answer not one cycle after setup");
endmodule : fpq_ctrl

// file: tb/fpq_flash_model.sv
// ==========================================
// Behavioural parallel flash: command decode, query table, region overlay
// Assumes word mode and the command codes of the controller package
module fpq_flash_model (
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic flashRstN,
  input wire logic flashHvEn,
  input wire logic flashEdgeLockN,
  input wire logic [fpq_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [fpq_pkg::DATA_W-1:0] dqBus,
  output logic [fpq_pkg::DATA_W-1:0] dqDrive,
  output logic protoErr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic queryOn = 1'b0;
  logic regionOn = 1'b0;
  logic [1:0] seqSt = 2'h0;
  logic [fpq_pkg::ADDR_W-1:0] lastAddr = 21'h000000;
  logic [fpq_pkg::DATA_W-1:0] lastData = 16'h0000;
  // Customer-lockable part; group 0 protected at start
  localparam logic FACTORY_LOCK = 1'b0;
  localparam logic [15:0] GRP_PROT = 16'h0001;
  int progWords = 0;
  int progBlocked = 0;
  // Supply ramps up during the first 20 ns
  logic supplyUp = 1'b0;
  initial protoErr = 1'b0;
  initial #20 supplyUp = 1'b1;

  // Whether a plain data write may change the word at this address
  function automatic logic canWrite(input logic [20:0] a);
    if (regionOn) begin
      return !FACTORY_LOCK && a < 21'h000080;
    end
    if (!flashEdgeLockN && (a[20:15] == 6'h00 || a[20:15] == 6'h3F)) begin
      return 1'b0;
    end
    return !GRP_PROT[a[20:17]] || flashHvEn;
  endfunction : canWrite

  function automatic logic [15:0] readVal(input logic [20:0] a);
    if (queryOn) begin
      case (a)
        21'h000010: return 16'h0051;
        21'h000011: return 16'h0052;
        21'h000012: return 16'h0059;
        21'h000013: return 16'h0002;
        21'h000015: return 16'h0040;
        default: return 16'h0000;
      endcase
    end
    if (regionOn && a < (FACTORY_LOCK ? 21'h000008 : 21'h000080)) begin
      return {8'hC0, FACTORY_LOCK, a[6:0]};
    end
    return a[15:0] ^ 16'hA5A5;
  endfunction : readVal

  // Released bus shows the inverse, never a held value
  always_comb begin
    dqDrive = (!flashCeN && !flashOeN) ? readVal(flashAddr) : ~readVal(flashAddr);
  end

  always @(negedge flashWeN) begin
    if (!flashCeN && !flashOeN) begin
      protoErr = 1'b1;
    end
  end

  always @(posedge flashWeN or negedge flashRstN) begin
    if (!flashRstN) begin
      queryOn = 1'b0;
      regionOn = 1'b0;
      seqSt = 2'h0;
    end else if (!supplyUp) begin
      queryOn = 1'b0;
      seqSt = 2'h0;
    end else if (!flashCeN && flashOeN) begin
      lastAddr = flashAddr;
      lastData = dqBus;
      if (dqBus == fpq_pkg::CMD_RESET) begin
        queryOn = 1'b0;
        seqSt = 2'h0;
      end else if (dqBus == fpq_pkg::CMD_QUERY && flashAddr == fpq_pkg::ADR_QUERY) begin
        queryOn = 1'b1;
      end else if (seqSt == 2'h0 && dqBus == fpq_pkg::CMD_UNLOCK1 && flashAddr == fpq_pkg::ADR_UNLOCK1) begin
        seqSt = 2'h1;
      end else if (seqSt == 2'h1 && dqBus == fpq_pkg::CMD_UNLOCK2 && flashAddr == fpq_pkg::ADR_UNLOCK2) begin
        seqSt = 2'h2;
      end else if (seqSt == 2'h2 && dqBus == fpq_pkg::CMD_REG_ENTER) begin
        regionOn = 1'b1;
        seqSt = 2'h0;
      end else if (seqSt == 2'h2 && dqBus == fpq_pkg::CMD_REG_EXIT1) begin
        seqSt = 2'h3;
      end else if (seqSt == 2'h3 && dqBus == fpq_pkg::CMD_REG_EXIT2) begin
        regionOn = 1'b0;
        seqSt = 2'h0;
      end else begin
        seqSt = 2'h0;
        if (canWrite(flashAddr)) begin
          progWords++;
        end else begin
          progBlocked++;
        end
      end
    end
  end
endmodule : fpq_flash_model

// file: tb/fpq_ctrl_test.sv
// ==========================================
// Self-checking bench for the flash controller over APB
// Assumes the behavioural flash model on the pins
module fpq_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] ctlHi = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, flashCeN, flashOeN, flashWeN, flashDqOe, flashRstN, flashHvEn, flashEdgeLockN, protoErr;
  logic [fpq_pkg::ADDR_W-1:0] flashAddr;
  logic [fpq_pkg::DATA_W-1:0] flashDqOut, dqDrive, dqBus;
  int bad_count = 0;
  int n_checks = 0;

  assign dqBus = flashDqOe ? flashDqOut : dqDrive;
  always #2 sys_clk = ~sys_clk;

  fpq_ctrl dut_u (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .flashAddr(flashAddr),
    .flashDqIn(dqBus), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashRstN(flashRstN),
    .flashHvEn(flashHvEn), .flashEdgeLockN(flashEdgeLockN));
  fpq_flash_model model_u (.flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .flashRstN(flashRstN), .flashHvEn(flashHvEn), .flashEdgeLockN(flashEdgeLockN), .flashAddr(flashAddr),
    .dqBus(dqBus), .dqDrive(dqDrive), .protoErr(protoErr));

  // ==========================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Runs an op, checks {queryOn, regionOn, err, done}
  task chkOp(input logic [2:0] op, input logic [31:0] a, input logic [3:0] exp);
    logic [31:0] st;
    int n;
    apb(1'b1, fpq_pkg::OFS_ADDR, a, rd, er);
    apb(1'b1, fpq_pkg::OFS_CTRL, {28'h0, op, 1'b1} | ctlHi, rd, er);
    st = 32'h0;
    n = 0;
    while (st[1] !== 1'b1 && st[2] !== 1'b1 && n < 100) begin
      apb(1'b0, fpq_pkg::OFS_STAT, 32'h0, st, er);
      n++;
    end
    chk(32'({st[5:4], st[2:1]}), 32'(exp));
    apb(1'b1, fpq_pkg::OFS_STAT, 32'h6, rd, er);
  endtask : chkOp

  task rdChk(input logic [31:0] a, input logic [3:0] st, input logic [31:0] exp);
    chkOp(3'h1, a, st);
    apb(1'b0, fpq_pkg::OFS_RDATA, 32'h0, rd, er);
    chk(rd, exp);
  endtask : rdChk

  function automatic logic [31:0] expQ(input int i);
    case (i)
      16'h10: return 32'h51;
      16'h11: return 32'h52;
      16'h12: return 32'h59;
      16'h13: return 32'h02;
      16'h15: return 32'h40;
      default: return 32'h0;
    endcase
  endfunction : expQ

  task wrap_up;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // ==========================================
  // Scenarios
  task testQuery;
    chkOp(3'h2, 32'h0, 4'h9);
    chkOp(3'h6, 32'h0, 4'h9);
    apb(1'b0, fpq_pkg::OFS_STAT, 32'h0, rd, er);
    chk(32'(rd[3]), 32'h1);
    for (int i = 16'h10; i <= 16'h1A; i++) begin
      rdChk(i, 4'h9, expQ(i));
    end
    chkOp(3'h4, 32'h0, 4'hA);
    chkOp(3'h3, 32'h1234, 4'h1);
    rdChk(32'h13, 4'h1, 32'hA5B6);
  endtask : testQuery

  task testRegion;
    chkOp(3'h4, 32'h0, 4'h5);
    rdChk(32'h5, 4'h5, 32'hC005);
    chkOp(3'h1, 32'h100, 4'h6);
    chkOp(3'h2, 32'h0, 4'h6);
    chkOp(3'h5, 32'h0, 4'h1);
    rdChk(32'h5, 4'h1, 32'hA5A0);
    chkOp(3'h4, 32'h0, 4'h5);
    chkOp(3'h7, 32'h0, 4'h1);
    rdChk(32'h5, 4'h1, 32'hA5A0);
  endtask : testRegion

  task testPins;
    apb(1'b1, fpq_pkg::OFS_WDATA, 32'h1234, rd, er);
    chkOp(3'h0, 32'h40, 4'h1);
    chk(32'({model_u.lastAddr, model_u.lastData}), 32'({21'h40, 16'h1234}));
    chk(model_u.progBlocked, 32'h1);
    ctlHi = 32'h100;
    chkOp(3'h0, 32'h40, 4'h1);
    chk(model_u.progWords, 32'h1);
    ctlHi = 32'h300;
    chkOp(3'h0, 32'h40, 4'h1);
    chk(model_u.progBlocked, 32'h2);
    ctlHi = 32'h0;
    chkOp(3'h0, 32'h8000, 4'h1);
    chkOp(3'h0, 32'h20000, 4'h1);
    chk(32'({model_u.progWords[3:0], model_u.progBlocked[3:0]}), 32'h23);
    apb(1'b1, fpq_pkg::OFS_CTRL, 32'h100, rd, er);
    apb(1'b0, fpq_pkg::OFS_STAT, 32'h0, rd, er);
    chk(32'({flashHvEn, flashEdgeLockN, rd[6]}), 32'h7);
    apb(1'b1, fpq_pkg::OFS_CTRL, 32'h200, rd, er);
    apb(1'b0, fpq_pkg::OFS_CTRL, 32'h0, rd, er);
    chk(rd, 32'h200);
    chk(32'({flashHvEn, flashEdgeLockN}), 32'h0);
    apb(1'b1, fpq_pkg::OFS_CTRL, 32'h0, rd, er);
    chk(32'(protoErr), 32'h0);
  endtask : testPins

  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    chk(32'({flashCeN, flashOeN, flashWeN, flashDqOe, flashRstN, flashHvEn, flashEdgeLockN}), 32'h75);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    testQuery();
    testRegion();
    testPins();
    wrap_up();
  end

  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule : fpq_ctrl_test
